// ---- hdl/bmc_pkg.sv ----
// Purpose: Constants shared by the battery monitor mode control block
// Assumes: 25 MHz device clock
// Notes:   Times in their own unit, cycle counts derived from them
package bmc_pkg;

    // ---------------------------------------------------------------
    // Clock and timing
    // ---------------------------------------------------------------
    localparam int unsigned CLK_HZ           = 25000000;
    localparam int unsigned SUPPLY_SETTLE_US = 3000;
    localparam int unsigned SETTLE_CYCLES    =
        (CLK_HZ / 1000000) * SUPPLY_SETTLE_US;
    localparam int unsigned CONV_CYCLES_DEF  = 64;
    localparam int unsigned FILT_CYCLES_DEF  = 32;

    // ---------------------------------------------------------------
    // Widths
    // ---------------------------------------------------------------
    localparam int unsigned CNT_W      = 24;
    localparam int unsigned PERIOD_W   = 16;
    localparam int unsigned CELL_COUNT = 6;
    localparam int unsigned CHAN_COUNT = CELL_COUNT + 1;

    localparam logic [CNT_W-1:0]    CNT_ZERO    = 24'h000000;
    localparam logic [CNT_W-1:0]    CNT_ONE     = 24'h000001;
    localparam logic [PERIOD_W-1:0] PERIOD_ZERO = 16'h0000;
    localparam logic [PERIOD_W-1:0] PERIOD_ONE  = 16'h0001;
    localparam logic [PERIOD_W-1:0] PERIOD_DEF  = 16'h0100;

    // ---------------------------------------------------------------
    // Sequencer states
    // ---------------------------------------------------------------
    typedef enum logic [2:0] {
        BMC_SLEEP   = 3'b000,
        BMC_SETTLE  = 3'b001,
        BMC_IDLE    = 3'b010,
        BMC_CONVERT = 3'b011,
        BMC_FILTER  = 3'b100
    } bmc_state_t;

endpackage

// ---- hdl/bmc_wakeup_timer.sv ----
// Purpose: Low-frequency wake-up tick timer
// Assumes: Enable gated by the active state
// Notes:   Once started only sleep stops it
`timescale 1ns/1ns
module bmc_wakeup_timer
(
    input  wire logic                          mclk,
    input  wire logic                          reset_n,
    input  wire logic                          active,
    input  wire logic                          start,
    input  wire logic                          restart,
    input  wire logic                          load_period,
    input  wire logic [bmc_pkg::PERIOD_W-1:0]  period_in,
    output logic                               running,
    output logic                               expire
);

    logic                         armed;
    logic                         next_armed;
    logic [bmc_pkg::PERIOD_W-1:0] period;
    logic [bmc_pkg::PERIOD_W-1:0] next_period;
    logic [bmc_pkg::PERIOD_W-1:0] count;
    logic [bmc_pkg::PERIOD_W-1:0] next_count;
    logic                         next_expire;

    // ---------------------------------------------------------------
    // Next state
    // ---------------------------------------------------------------
    always_comb
    begin
        next_armed  = armed;
        next_period = period;
        next_count  = count;
        next_expire = 1'b0;
        if (!active)
        begin
            next_armed  = 1'b0;
            next_period = bmc_pkg::PERIOD_DEF;
            next_count  = bmc_pkg::PERIOD_ZERO;
        end
        else
        begin
            if (load_period && period_in != bmc_pkg::PERIOD_ZERO)
            begin
                next_period = period_in;
            end
            if (start)
            begin
                next_armed = 1'b1;
            end
            if (restart || (start && !armed))
            begin
                next_count = bmc_pkg::PERIOD_ZERO;
            end
            else if (armed)
            begin
                if (count + bmc_pkg::PERIOD_ONE >= period)
                begin
                    next_count  = bmc_pkg::PERIOD_ZERO;
                    next_expire = 1'b1;
                end
                else
                begin
                    next_count = count + bmc_pkg::PERIOD_ONE;
                end
            end
        end
    end

    // ---------------------------------------------------------------
    // Registers
    // ---------------------------------------------------------------
    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            armed  <= 1'b0;
            period <= bmc_pkg::PERIOD_DEF;
            count  <= bmc_pkg::PERIOD_ZERO;
            expire <= 1'b0;
        end
        else
        begin
            armed  <= next_armed;
            period <= next_period;
            count  <= next_count;
            expire <= next_expire;
        end
    end

    assign running = armed;

endmodule

// ---- hdl/bmc_mode_control.sv ----
// Purpose: Sleep/active sequencing, acquisition and interrupt for a
//          stackable battery-cell monitor
// Assumes: Host commands arrive as one-cycle strobes from the serial
//          front end; all inputs synchronous to mclk
// Notes:   Converter and filter durations are parameters
//
// How it works
// - Five states: sleep with all off, then settle, idle, convert and filter while active.
// - In sleep, converters, timer and communication are held off.
// - Active while standby release input high, sleep when low.
// - Rising release input switches on analog and digital supplies.
// - Microcontroller supply enabled on wake only with regulator enable.
// - Wake reloads configuration defaults before host commands are taken.
// - Chained standby output relays own state to next lower device.
// - Acquisition command converts all cells and one temperature together.
// - Data-ready interrupt raised once conversion and filtering finish.
// - Pending interrupt shown as high level on interrupt output.
// - Activatable wake-up timer whose expiry raises the interrupt.
// - Timer takes new period and restart, never a stop command.
`timescale 1ns/1ns
module bmc_mode_control
#(
    parameter int unsigned SETTLE_CYCLES = bmc_pkg::SETTLE_CYCLES,
    parameter int unsigned CONV_CYCLES   = bmc_pkg::CONV_CYCLES_DEF,
    parameter int unsigned FILT_CYCLES   = bmc_pkg::FILT_CYCLES_DEF
)
(
    input  wire logic                              mclk,
    input  wire logic                              reset_n,
    input  wire logic                              standby_release_in,
    input  wire logic                              mcu_regulator_enable,
    input  wire logic                              acquire_cmd,
    input  wire logic                              status_read,
    input  wire logic                              timer_start_cmd,
    input  wire logic                              timer_restart_cmd,
    input  wire logic                              timer_period_wr,
    input  wire logic [bmc_pkg::PERIOD_W-1:0]      timer_period,
    output logic                                   standby_release_chain_out,
    output logic                                   analog_core_supply,
    output logic                                   digital_core_supply,
    output logic                                   mcu_supply_out,
    output logic                                   comm_enable,
    output logic                                   config_load_defaults,
    output logic                                   ready,
    output logic [bmc_pkg::CHAN_COUNT-1:0]         convert_enable,
    output logic                                   filter_busy,
    output logic                                   data_ready,
    output logic                                   timer_pending,
    output logic                                   timer_running,
    output logic                                   irq
);

    bmc_pkg::bmc_state_t           state;
    bmc_pkg::bmc_state_t           next_state;
    logic [bmc_pkg::CNT_W-1:0]     count;
    logic [bmc_pkg::CNT_W-1:0]     next_count;
    logic                          release_q;
    logic                          mcu_on;
    logic                          next_mcu_on;
    logic                          next_data_ready;
    logic                          next_timer_pending;
    logic                          next_load;
    logic                          active;
    logic                          wake;
    logic                          timer_expire;

    localparam logic [bmc_pkg::CNT_W-1:0] SETTLE_END =
        bmc_pkg::CNT_W'(SETTLE_CYCLES - 1);
    localparam logic [bmc_pkg::CNT_W-1:0] CONV_END =
        bmc_pkg::CNT_W'(CONV_CYCLES - 1);
    localparam logic [bmc_pkg::CNT_W-1:0] FILT_END =
        bmc_pkg::CNT_W'(FILT_CYCLES - 1);

    assign wake   = standby_release_in && !release_q;
    assign active = standby_release_in && (state != bmc_pkg::BMC_SLEEP);

    // ---------------------------------------------------------------
    // Sequencer next state
    // ---------------------------------------------------------------
    always_comb
    begin
        next_state  = state;
        next_count  = count;
        next_mcu_on = mcu_on;
        next_load   = 1'b0;
        if (!standby_release_in)
        begin
            next_state  = bmc_pkg::BMC_SLEEP;
            next_count  = bmc_pkg::CNT_ZERO;
            next_mcu_on = 1'b0;
        end
        else
        begin
            case (state)
                bmc_pkg::BMC_SLEEP:
                begin
                    if (wake)
                    begin
                        next_state  = bmc_pkg::BMC_SETTLE;
                        next_count  = bmc_pkg::CNT_ZERO;
                        next_mcu_on = mcu_regulator_enable;
                        next_load   = 1'b1;
                    end
                end
                bmc_pkg::BMC_SETTLE:
                begin
                    next_load = 1'b1;
                    if (count >= SETTLE_END)
                    begin
                        next_state = bmc_pkg::BMC_IDLE;
                        next_count = bmc_pkg::CNT_ZERO;
                    end
                    else
                    begin
                        next_count = count + bmc_pkg::CNT_ONE;
                    end
                end
                bmc_pkg::BMC_IDLE:
                begin
                    if (acquire_cmd)
                    begin
                        next_state = bmc_pkg::BMC_CONVERT;
                        next_count = bmc_pkg::CNT_ZERO;
                    end
                end
                bmc_pkg::BMC_CONVERT:
                begin
                    if (count >= CONV_END)
                    begin
                        next_state = bmc_pkg::BMC_FILTER;
                        next_count = bmc_pkg::CNT_ZERO;
                    end
                    else
                    begin
                        next_count = count + bmc_pkg::CNT_ONE;
                    end
                end
                bmc_pkg::BMC_FILTER:
                begin
                    if (count >= FILT_END)
                    begin
                        next_state = bmc_pkg::BMC_IDLE;
                        next_count = bmc_pkg::CNT_ZERO;
                    end
                    else
                    begin
                        next_count = count + bmc_pkg::CNT_ONE;
                    end
                end
                default:
                begin
                    next_state = bmc_pkg::BMC_SLEEP;
                    next_count = bmc_pkg::CNT_ZERO;
                end
            endcase
        end
    end

    // ---------------------------------------------------------------
    // Interrupt flags, set wins over acknowledge
    // ---------------------------------------------------------------
    always_comb
    begin
        next_data_ready    = data_ready;
        next_timer_pending = timer_pending;
        if (!standby_release_in || state == bmc_pkg::BMC_SLEEP)
        begin
            next_data_ready    = 1'b0;
            next_timer_pending = 1'b0;
        end
        else
        begin
            if (status_read)
            begin
                next_data_ready    = 1'b0;
                next_timer_pending = 1'b0;
            end
            if (state == bmc_pkg::BMC_FILTER && count >= FILT_END)
            begin
                next_data_ready = 1'b1;
            end
            if (timer_expire)
            begin
                next_timer_pending = 1'b1;
            end
        end
    end

    // ---------------------------------------------------------------
    // Registers
    // ---------------------------------------------------------------
    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            state                <= bmc_pkg::BMC_SLEEP;
            count                <= bmc_pkg::CNT_ZERO;
            release_q            <= 1'b0;
            mcu_on               <= 1'b0;
            config_load_defaults <= 1'b0;
            data_ready           <= 1'b0;
            timer_pending        <= 1'b0;
        end
        else
        begin
            state                <= next_state;
            count                <= next_count;
            release_q            <= standby_release_in;
            mcu_on               <= next_mcu_on;
            config_load_defaults <= next_load;
            data_ready           <= next_data_ready;
            timer_pending        <= next_timer_pending;
        end
    end

    // ---------------------------------------------------------------
    // Wake-up timer
    // ---------------------------------------------------------------
    bmc_wakeup_timer u_timer
    (
        .mclk        (mclk),
        .reset_n     (reset_n),
        .active      (ready && active),
        .start       (timer_start_cmd),
        .restart     (timer_restart_cmd),
        .load_period (timer_period_wr),
        .period_in   (timer_period),
        .running     (timer_running),
        .expire      (timer_expire)
    );

    // ---------------------------------------------------------------
    // Outputs
    // ---------------------------------------------------------------
    assign standby_release_chain_out = active;
    assign analog_core_supply        = active;
    assign digital_core_supply       = active;
    assign mcu_supply_out            = mcu_on && active;
    assign ready = active && state != bmc_pkg::BMC_SETTLE;
    assign comm_enable               = ready;
    assign convert_enable = {bmc_pkg::CHAN_COUNT{active &&
        state == bmc_pkg::BMC_CONVERT}};
    assign filter_busy = active && state == bmc_pkg::BMC_FILTER;
    assign irq = data_ready || timer_pending;

endmodule

// ---- sim/bmc_properties.sv ----
// Purpose: Port-level temporal checks of the mode control block
// Assumes: Same counts as the bound instance
// Notes:   Bound at the foot of this file
`timescale 1ns/1ns
module bmc_properties
#(
    parameter int unsigned SETTLE_CYCLES = bmc_pkg::SETTLE_CYCLES,
    parameter int unsigned CONV_CYCLES   = bmc_pkg::CONV_CYCLES_DEF,
    parameter int unsigned FILT_CYCLES   = bmc_pkg::FILT_CYCLES_DEF
)
(
    input wire logic                          mclk,
    input wire logic                          reset_n,
    input wire logic                          standby_release_in,
    input wire logic                          mcu_regulator_enable,
    input wire logic                          acquire_cmd,
    input wire logic                          status_read,
    input wire logic                          standby_release_chain_out,
    input wire logic                          analog_core_supply,
    input wire logic                          digital_core_supply,
    input wire logic                          mcu_supply_out,
    input wire logic                          config_load_defaults,
    input wire logic                          ready,
    input wire logic [bmc_pkg::CHAN_COUNT-1:0] convert_enable,
    input wire logic                          filter_busy,
    input wire logic                          data_ready,
    input wire logic                          timer_pending,
    input wire logic                          timer_running
);
    localparam int RDY = SETTLE_CYCLES + 1;
    localparam int CM1 = CONV_CYCLES - 1;
    localparam int FM1 = FILT_CYCLES - 1;
    logic [bmc_pkg::CNT_W-1:0] awake_cnt;
    logic [bmc_pkg::CNT_W-1:0] next_awake_cnt;

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!reset_n);

    // Cycles spent with the release input high
    always_comb
        next_awake_cnt = standby_release_in ? awake_cnt + 24'h000001
                                            : 24'h000000;
    always_ff @(posedge mclk or negedge reset_n)
        if (!reset_n)
            awake_cnt <= 24'h000000;
        else
            awake_cnt <= next_awake_cnt;

    // ----------------------------------------------------------------
    // Properties
    // ----------------------------------------------------------------
    sequence s_wake;
        !standby_release_in ##1 standby_release_in [*2];
    endsequence
    sequence s_acq;
        acquire_cmd && ready && !filter_busy && !(|convert_enable);
    endsequence
    sequence s_run;
        (&convert_enable) ##CM1 (&convert_enable) ##1 filter_busy
            ##FM1 filter_busy ##1 data_ready;
    endsequence

    property p_sleep_off;
        !standby_release_in |-> !(analog_core_supply || digital_core_supply
            || standby_release_chain_out || mcu_supply_out || ready);
    endproperty
    a_sleep_off: assert property (p_sleep_off)
        else $error("awake in sleep");
    property p_mcu;
        $rose(mcu_supply_out) |-> $past(mcu_regulator_enable)
            && analog_core_supply && digital_core_supply;
    endproperty
    a_mcu: assert property (p_mcu) else $error("mcu supply ungated");
    property p_defaults;
        s_wake |-> config_load_defaults && !ready;
    endproperty
    a_defaults: assert property (p_defaults) else $error("no defaults");
    property p_ready;
        $rose(ready) |-> awake_cnt == RDY;
    endproperty
    a_ready: assert property (p_ready) else $error("ready timing");
    property p_acq;
        @(posedge mclk) disable iff (!reset_n || !standby_release_in)
        s_acq |=> s_run;
    endproperty
    a_acq: assert property (p_acq) else $error("acquisition timing");
    property p_hold;
        data_ready && !status_read && standby_release_in |=> data_ready;
    endproperty
    a_hold: assert property (p_hold) else $error("data ready lost");
    property p_ack;
        status_read && !filter_busy && standby_release_in |=> !data_ready;
    endproperty
    a_ack: assert property (p_ack) else $error("ack ignored");
    property p_nostop;
        timer_running && standby_release_in |=> timer_running;
    endproperty
    a_nostop: assert property (p_nostop) else $error("timer stopped");
    property p_abort;
        $fell(standby_release_in) |=> !(|convert_enable) && !filter_busy
            && !data_ready && !timer_pending && !timer_running;
    endproperty
    a_abort: assert property (p_abort)
        else $error("sleep kept work");
endmodule

bind bmc_mode_control bmc_properties #(
    .SETTLE_CYCLES(SETTLE_CYCLES),
    .CONV_CYCLES(CONV_CYCLES),
    .FILT_CYCLES(FILT_CYCLES)
) u_props
(
    .mclk(mclk), .reset_n(reset_n),
    .standby_release_in(standby_release_in),
    .mcu_regulator_enable(mcu_regulator_enable),
    .acquire_cmd(acquire_cmd), .status_read(status_read),
    .standby_release_chain_out(standby_release_chain_out),
    .analog_core_supply(analog_core_supply),
    .digital_core_supply(digital_core_supply),
    .mcu_supply_out(mcu_supply_out),
    .config_load_defaults(config_load_defaults), .ready(ready),
    .convert_enable(convert_enable), .filter_busy(filter_busy),
    .data_ready(data_ready), .timer_pending(timer_pending),
    .timer_running(timer_running)
);

// ---- sim/bmc_host_model.sv ----
// Purpose: Host side that answers the interrupt line
// Assumes: Acts on the falling edge like the bench
// Notes:   Lag stands for the result reads before the status read
`timescale 1ns/1ns
module bmc_host_model
(
    input  wire logic       mclk,
    input  wire logic       reset_n,
    input  wire logic       irq,
    input  wire logic       ack_on,
    input  wire logic [7:0] ack_lag,
    output logic            status_read
);
    logic [7:0] wait_cnt;

    initial
    begin
        status_read = 1'b0;
        wait_cnt = 8'h00;
    end
    always @(negedge mclk)
    begin
        status_read <= 1'b0;
        if (reset_n !== 1'b1 || irq !== 1'b1 || ack_on !== 1'b1)
            wait_cnt <= 8'h00;
        else if (wait_cnt >= ack_lag)
        begin
            status_read <= 1'b1;
            wait_cnt <= 8'h00;
        end
        else
            wait_cnt <= wait_cnt + 8'h01;
    end
endmodule

// ---- sim/battery_monitor_mode_control_test.sv ----
// Purpose: Self-checking bench for the mode control block
// Assumes: Inputs change on the falling edge
// Notes:   Short settle, conversion and filter counts
`timescale 1ns/1ns
module battery_monitor_mode_control_test;
    localparam int CV = 6;
    localparam int FT = 4;
    logic                         mclk, reset_n, standby_release_in;
    logic                         mcu_regulator_enable, acquire_cmd;
    logic                         status_read, timer_start_cmd, ack_on;
    logic                         timer_restart_cmd, timer_period_wr;
    logic                         standby_release_chain_out, ready;
    logic                         analog_core_supply, digital_core_supply;
    logic                         mcu_supply_out, comm_enable, irq;
    logic                         config_load_defaults, filter_busy;
    logic                         data_ready, timer_pending, timer_running;
    logic                         dr_q, tp_q;
    logic [bmc_pkg::PERIOD_W-1:0] timer_period;
    logic [bmc_pkg::CHAN_COUNT-1:0] convert_enable;
    logic [7:0]                   ack_lag;
    int                           bad_count, n_compared, cyc, seed;
    int                           dq[$], tq[$];

    bmc_mode_control #(.SETTLE_CYCLES(8), .CONV_CYCLES(CV),
        .FILT_CYCLES(FT)) uut
    (
        .mclk(mclk), .reset_n(reset_n),
        .standby_release_in(standby_release_in),
        .mcu_regulator_enable(mcu_regulator_enable),
        .acquire_cmd(acquire_cmd), .status_read(status_read),
        .timer_start_cmd(timer_start_cmd),
        .timer_restart_cmd(timer_restart_cmd),
        .timer_period_wr(timer_period_wr), .timer_period(timer_period),
        .standby_release_chain_out(standby_release_chain_out),
        .analog_core_supply(analog_core_supply),
        .digital_core_supply(digital_core_supply),
        .mcu_supply_out(mcu_supply_out), .comm_enable(comm_enable),
        .config_load_defaults(config_load_defaults), .ready(ready),
        .convert_enable(convert_enable), .filter_busy(filter_busy),
        .data_ready(data_ready), .timer_pending(timer_pending),
        .timer_running(timer_running), .irq(irq)
    );
    bmc_host_model host
    (
        .mclk(mclk), .reset_n(reset_n), .irq(irq), .ack_on(ack_on),
        .ack_lag(ack_lag), .status_read(status_read)
    );

    initial
    begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end
    always @(posedge mclk)
        cyc <= cyc + 1;

    task automatic end_of_test;
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic fail(input logic [31:0] got, input logic [31:0] exp);
        bad_count++;
        $display("Error t=%0t got %h exp %h", $time, got, exp);
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp)
            fail(got, exp);
    endtask
    task automatic take(ref int q[$], input int tol);
        int e;
        n_compared++;
        e = (q.size() == 0) ? -99 : q.pop_front();
        if (cyc > e + tol || cyc + tol < e)
            fail(cyc, e);
    endtask
    task automatic tick(input int n);
        repeat (n) @(negedge mclk);
    endtask
    task automatic pulse(ref logic s);
        s = 1'b1;
        tick(1);
        s = 1'b0;
    endtask
    task automatic wait_for(ref logic s, input int lim);
        int i;
        for (i = 0; i < lim && s !== 1'b1; i++)
            tick(1);
        if (i == lim)
        begin
            fail(0, 1);
            end_of_test();
        end
    endtask

    // ----------------------------------------------------------------
    // Watcher: each rising result takes the oldest note
    // ----------------------------------------------------------------
    always @(negedge mclk)
    begin
        dr_q <= data_ready;
        tp_q <= timer_pending;
        if (data_ready === 1'b1 && dr_q === 1'b0)
            take(dq, 0);
        if (timer_pending === 1'b1 && tp_q === 1'b0)
            take(tq, 0);
    end

    initial
    begin
        {standby_release_in, mcu_regulator_enable, acquire_cmd} = 3'h0;
        {timer_start_cmd, timer_restart_cmd, timer_period_wr} = 3'h0;
        {reset_n, dr_q, tp_q, ack_on} = 4'h1;
        {bad_count, n_compared, cyc} = 0;
        timer_period = 16'h0000;
        ack_lag = 8'h03;
        seed = 32'h4A08;
        tick(12);
        reset_n <= 1'b1;
        tick(2);
        check({standby_release_chain_out, analog_core_supply, irq}, 3'h0);
        for (int k = 0; k < 2; k++)
        begin
            mcu_regulator_enable <= k[0];
            standby_release_in <= 1'b1;
            tick(2);
            check({standby_release_chain_out, analog_core_supply,
                digital_core_supply, mcu_supply_out, config_load_defaults},
                {3'h7, k[0], 1'b1});
            pulse(acquire_cmd);
            pulse(timer_start_cmd);
            wait_for(ready, 20);
            check({comm_enable, timer_running, |convert_enable}, 3'h4);
            standby_release_in <= k[0];
            tick(2);
            check({mcu_supply_out, analog_core_supply}, {2{k[0]}});
        end
        repeat (3)
        begin
            ack_lag <= 8'(1 + ($random(seed) & 7));
            dq.push_back(cyc + CV + FT + 1);
            pulse(acquire_cmd);
            tick(1);
            pulse(acquire_cmd);
            wait_for(data_ready, 40);
            tick(12);
            check(data_ready, 1'b0);
        end
        ack_on <= 1'b0;
        dq.push_back(cyc + CV + FT + 1);
        pulse(acquire_cmd);
        tick(40);
        check({irq, data_ready}, 2'h3);
        ack_on <= 1'b1;
        tick(12);
        check(irq, 1'b0);
        timer_period <= 16'(20 + ($random(seed) & 31));
        pulse(timer_period_wr);
        tq.push_back(cyc + int'(timer_period) + 2);
        tq.push_back(cyc + 2 * int'(timer_period) + 2);
        pulse(timer_start_cmd);
        wait_for(timer_pending, 80);
        tick(10);
        wait_for(timer_pending, 80);
        tick(10);
        timer_period <= 16'(20 + ($random(seed) & 31));
        pulse(timer_period_wr);
        tq.push_back(cyc + int'(timer_period) + 2);
        pulse(timer_restart_cmd);
        wait_for(timer_pending, 80);
        tick(10);
        check(timer_running, 1'b1);
        pulse(acquire_cmd);
        tick(3);
        standby_release_in <= 1'b0;
        tick(2);
        check({convert_enable, filter_busy, data_ready, timer_running},
            10'h000);
        check(dq.size() + tq.size(), 0);
        end_of_test();
    end
endmodule
